// ==== sysconf_bank.sv ====
// System configuration bank: permission groups, identifiers, key and boot configuration
`timescale 1ns/1ps
`include "sysconf_params.svh"

// Notes on behaviour
// - Two-bit code picks group zero to three
// - USB, quad serial, Ethernet, crypto in 23-16
// - CAN2, CAN1, converter, wireless in 15-8
// - Debug, DMA, flash, CPU in 7-0
// - CPU bus group follows core guest identifier
// - Group fields lockable, reset zero, top zero
// - Identifier: revision 31-28, device 27-0
// - Lockable 16-bit user ID, also JTAG
// - Key register 32-bit RW, watched by lock
// - Two key words in a row unlock, idle cycles between allowed
// - Any other key value relocks
// - Bit 31 flags untrusted boot values
// - Bit 29 reports flash signature state
// - Bit 28 reports code protection
// - Bit 3 picks standard or compressed set
// - Debug boots use debug-control ISA bit
// - Bit 1 routes all fetches to one cache
// - Boot register read-only, loaded after reset release
// - Blank device boots in standard set
module sysconf_bank #(
    parameter logic [3:0] REVISION_NUMBER = 4'h1, // Arbitrary value
    parameter logic [27:0] DEVICE_IDENTIFIER = 28'h0000abc // Arbitrary value
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Register access
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire sysconf_pkg::word_t reg_wdata_in,
    output sysconf_pkg::word_t reg_rdata_out,
    // Boot values from flash, sampled in the cycle after reset release
    input wire logic flash_programmed_in,
    input wire logic flash_trusted_in,
    input wire logic flash_signed_in,
    input wire logic flash_code_protect_in,
    input wire logic flash_boot_isa_in,
    input wire logic flash_single_cache_in,
    // Debug boot controls
    input wire logic debug_boot_path_in,
    input wire logic debug_boot_instruction_set_in,
    // CPU guest identifier and JTAG read
    input wire sysconf_pkg::perm_group_t core_guest_identifier_in,
    input wire logic jtag_user_id_read_in,
    output logic [15:0] jtag_user_id_out,
    // Group numbers sent with each initiator's transactions
    output sysconf_pkg::perm_group_t usb_initiator_group_out,
    output sysconf_pkg::perm_group_t quad_serial_initiator_group_out,
    output sysconf_pkg::perm_group_t ethernet_initiator_group_out,
    output sysconf_pkg::perm_group_t crypto_initiator_group_out,
    output sysconf_pkg::perm_group_t second_can_initiator_group_out,
    output sysconf_pkg::perm_group_t first_can_initiator_group_out,
    output sysconf_pkg::perm_group_t converter_initiator_group_out,
    output sysconf_pkg::perm_group_t wireless_initiator_group_out,
    output sysconf_pkg::perm_group_t debug_initiator_group_out,
    output sysconf_pkg::perm_group_t dma_initiator_group_out,
    output sysconf_pkg::perm_group_t flash_controller_initiator_group_out,
    output sysconf_pkg::perm_group_t cpu_code_initiator_group_out,
    output sysconf_pkg::perm_group_t cpu_bus_group_out,
    // Boot results and lock state
    output logic boot_instruction_set_out,
    output logic single_cache_route_select_out,
    output logic code_protection_flag_out,
    output logic system_unlocked_out
);
    import sysconf_pkg::*;

    function automatic perm_group_t group_at(input logic [23:0] groups, input int lsb);
        group_at = groups[lsb +: 2];
    endfunction : group_at

    logic [23:0] initiator_permission_groups;
    logic [23:0] next_initiator_permission_groups;
    logic [15:0] user_unique_identifier;
    logic [15:0] next_user_unique_identifier;
    word_t system_unlock_key;
    word_t next_system_unlock_key;
    word_t boot_configuration;
    word_t next_boot_configuration;
    logic boot_loaded;
    logic next_boot_loaded;
    word_t rdata;
    word_t next_rdata;
    logic [15:0] jtag_id;
    logic [15:0] next_jtag_id;
    logic isa_out;
    logic next_isa_out;
    perm_group_t cpu_group;
    logic unlocked;
    logic key_write;
    logic other_write;

    assign key_write = reg_write_in && reg_addr_in == `ADDR_SYSTEM_UNLOCK_KEY;
    assign other_write = reg_write_in && !key_write;

    sysconf_unlock u_unlock (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .key_write_in(key_write),
        .key_data_in(reg_wdata_in),
        .other_write_in(other_write),
        .unlocked_out(unlocked)
    );

    // Boot word is captured once, after release, because async reset takes constants only
    always_comb begin
        next_boot_configuration = boot_configuration;
        next_boot_loaded = 1'b1;
        if (!boot_loaded) begin
            next_boot_configuration = '0;
            if (flash_programmed_in && flash_trusted_in) begin
                next_boot_configuration[`BOOT_ISA_BIT] = flash_boot_isa_in;
                next_boot_configuration[`BOOT_SINGLE_CACHE_BIT] = flash_single_cache_in;
            end else begin
                next_boot_configuration[`BOOT_ISA_BIT] = `BOOT_ISA_BLANK;
                next_boot_configuration[`BOOT_UNTRUSTED_BIT] = 1'b1;
            end
            next_boot_configuration[`BOOT_SIGN_BIT] = !flash_signed_in;
            next_boot_configuration[`BOOT_CODE_PROTECT_BIT] = flash_code_protect_in;
        end
    end

    // Register writes
    always_comb begin
        next_initiator_permission_groups = initiator_permission_groups;
        next_user_unique_identifier = user_unique_identifier;
        next_system_unlock_key = system_unlock_key;
        if (reg_write_in) begin
            unique case (reg_addr_in)
                `ADDR_PERMISSION_GROUPS: begin
                    if (unlocked) begin
                        next_initiator_permission_groups = reg_wdata_in[23:0];
                    end
                end
                `ADDR_USER_UNIQUE_ID: begin
                    if (unlocked) begin
                        next_user_unique_identifier = reg_wdata_in[15:0];
                    end
                end
                `ADDR_SYSTEM_UNLOCK_KEY: begin
                    next_system_unlock_key = reg_wdata_in;
                end
                default: begin
                end
            endcase
        end
    end

    // Read data, registered; unmapped reads as zero
    always_comb begin
        next_rdata = rdata;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                `ADDR_BOOT_CONFIGURATION: next_rdata = boot_configuration;
                `ADDR_PERMISSION_GROUPS: next_rdata = {8'h00, initiator_permission_groups};
                `ADDR_DEVICE_REVISION_ID: next_rdata = {REVISION_NUMBER, DEVICE_IDENTIFIER};
                `ADDR_USER_UNIQUE_ID: next_rdata = {16'h0000, user_unique_identifier};
                `ADDR_SYSTEM_UNLOCK_KEY: next_rdata = system_unlock_key;
                default: next_rdata = '0;
            endcase
        end
    end

    always_comb begin
        next_jtag_id = jtag_id;
        if (jtag_user_id_read_in) begin
            next_jtag_id = user_unique_identifier;
        end
        // Debug boots ignore the stored ISA selection
        next_isa_out = debug_boot_path_in ? debug_boot_instruction_set_in
                                          : boot_configuration[`BOOT_ISA_BIT];
    end

    // Guest identifier may move on interrupt entry, so it is registered afresh every cycle rather than held
    assign cpu_group = core_guest_identifier_in;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            initiator_permission_groups <= `PERM_RESET;
            user_unique_identifier <= `USER_UNIQUE_IDENTIFIER_RESET;
            system_unlock_key <= `SYSTEM_UNLOCK_KEY_RESET;
            boot_configuration <= '0;
            boot_loaded <= 1'b0;
            rdata <= '0;
            jtag_id <= '0;
            isa_out <= `BOOT_ISA_BLANK;
            cpu_bus_group_out <= '0;
            system_unlocked_out <= 1'b0;
        end else begin
            initiator_permission_groups <= next_initiator_permission_groups;
            user_unique_identifier <= next_user_unique_identifier;
            system_unlock_key <= next_system_unlock_key;
            boot_configuration <= next_boot_configuration;
            boot_loaded <= next_boot_loaded;
            rdata <= next_rdata;
            jtag_id <= next_jtag_id;
            isa_out <= next_isa_out;
            cpu_bus_group_out <= cpu_group;
            system_unlocked_out <= unlocked;
        end
    end

    // Group outputs drawn straight from the permission flip-flops
    assign usb_initiator_group_out = group_at(initiator_permission_groups, `PERM_USB_LSB);
    assign quad_serial_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_QUAD_SERIAL_LSB);
    assign ethernet_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_ETHERNET_LSB);
    assign crypto_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_CRYPTO_LSB);
    assign second_can_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_SECOND_CAN_LSB);
    assign first_can_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_FIRST_CAN_LSB);
    assign converter_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_CONVERTER_LSB);
    assign wireless_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_WIRELESS_LSB);
    assign debug_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_DEBUG_LSB);
    assign dma_initiator_group_out = group_at(initiator_permission_groups, `PERM_DMA_LSB);
    assign flash_controller_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_FLASH_CTRL_LSB);
    assign cpu_code_initiator_group_out =
        group_at(initiator_permission_groups, `PERM_CPU_CODE_LSB);
    assign reg_rdata_out = rdata;
    assign jtag_user_id_out = jtag_id;
    assign boot_instruction_set_out = isa_out;
    assign single_cache_route_select_out = boot_configuration[`BOOT_SINGLE_CACHE_BIT];
    assign code_protection_flag_out = boot_configuration[`BOOT_CODE_PROTECT_BIT];

    property p_locked_perm_hold;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (reg_write_in && reg_addr_in == `ADDR_PERMISSION_GROUPS && !unlocked)
            |=> $stable(initiator_permission_groups);
    endproperty
    a_locked_perm_hold: assert property (p_locked_perm_hold)
        else $error("locked write changed groups");

    property p_locked_user_hold;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (reg_write_in && reg_addr_in == `ADDR_USER_UNIQUE_ID && !unlocked)
            |=> $stable(user_unique_identifier);
    endproperty
    a_locked_user_hold: assert property (p_locked_user_hold)
        else $error("locked write changed user id");

    property p_unlocked_perm_write;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (reg_write_in && reg_addr_in == `ADDR_PERMISSION_GROUPS && unlocked)
            |=> usb_initiator_group_out == $past(reg_wdata_in[23:22])
                && cpu_code_initiator_group_out == $past(reg_wdata_in[1:0]);
    endproperty
    a_unlocked_perm_write: assert property (p_unlocked_perm_write)
        else $error("group write lost");

    property p_perm_read_top_zero;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (reg_read_in && reg_addr_in == `ADDR_PERMISSION_GROUPS) |=> reg_rdata_out[31:24] == 8'h00;
    endproperty
    a_perm_read_top_zero: assert property (p_perm_read_top_zero)
        else $error("group top bits set");

    property p_device_revision_identifier_read;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (reg_read_in && reg_addr_in == `ADDR_DEVICE_REVISION_ID)
            |=> reg_rdata_out == {REVISION_NUMBER, DEVICE_IDENTIFIER};
    endproperty
    a_device_revision_identifier_read: assert property (p_device_revision_identifier_read) else $error("identifier read wrong");

    property p_jtag_matches_user;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        jtag_user_id_read_in |=> jtag_user_id_out == $past(user_unique_identifier);
    endproperty
    a_jtag_matches_user: assert property (p_jtag_matches_user)
        else $error("jtag user id mismatch");

    property p_boot_read_only;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        boot_loaded ##1 boot_loaded |-> $stable(boot_configuration);
    endproperty
    a_boot_read_only: assert property (p_boot_read_only) else $error("boot word changed");

    property p_untrusted_safe_isa;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        $rose(boot_loaded) && boot_configuration[`BOOT_UNTRUSTED_BIT]
            |-> boot_configuration[`BOOT_ISA_BIT] && !boot_configuration[`BOOT_SINGLE_CACHE_BIT];
    endproperty
    a_untrusted_safe_isa: assert property (p_untrusted_safe_isa)
        else $error("unsafe boot defaults");

    property p_debug_isa;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        debug_boot_path_in |=> boot_instruction_set_out == $past(debug_boot_instruction_set_in);
    endproperty
    a_debug_isa: assert property (p_debug_isa) else $error("debug boot ISA wrong");

    property p_cpu_group;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        // Sampled reset keeps the release edge, where the flop still resets, out
        arst_n_in |=> cpu_bus_group_out == $past(core_guest_identifier_in);
    endproperty
    a_cpu_group: assert property (p_cpu_group) else $error("cpu group not from guest id");

    property p_key_stored;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (reg_write_in && reg_addr_in == `ADDR_SYSTEM_UNLOCK_KEY)
            |=> system_unlock_key == $past(reg_wdata_in);
    endproperty
    a_key_stored: assert property (p_key_stored) else $error("key write not stored");
endmodule : sysconf_bank

// ==== sysconf_params.svh ====
// Offsets, field positions, reset values and key constants of the system configuration bank
`ifndef SYSCONF_PARAMS_SVH
`define SYSCONF_PARAMS_SVH

`define ADDR_BOOT_CONFIGURATION 12'h100
`define ADDR_PERMISSION_GROUPS 12'h110
`define ADDR_DEVICE_REVISION_ID 12'h120
`define ADDR_USER_UNIQUE_ID 12'h130
`define ADDR_SYSTEM_UNLOCK_KEY 12'h140

`define PERM_USB_LSB 22
`define PERM_QUAD_SERIAL_LSB 20
`define PERM_ETHERNET_LSB 18
`define PERM_CRYPTO_LSB 16
`define PERM_SECOND_CAN_LSB 14
`define PERM_FIRST_CAN_LSB 12
`define PERM_CONVERTER_LSB 10
`define PERM_WIRELESS_LSB 8
`define PERM_DEBUG_LSB 6
`define PERM_DMA_LSB 4
`define PERM_FLASH_CTRL_LSB 2
`define PERM_CPU_CODE_LSB 0
`define PERM_USED_WIDTH 24
`define PERM_RESET 24'h000000

`define DEVICE_REVISION_IDENTIFIER_REV_LSB 28
`define DEVICE_REVISION_IDENTIFIER_DEV_WIDTH 28
`define USER_UNIQUE_IDENTIFIER_WIDTH 16
`define USER_UNIQUE_IDENTIFIER_RESET 16'h0000
`define SYSTEM_UNLOCK_KEY_RESET 32'h00000000

`define KEY_FIRST 32'haa996655
`define KEY_SECOND 32'h556699aa

`define BOOT_UNTRUSTED_BIT 31
`define BOOT_SIGN_BIT 29
`define BOOT_CODE_PROTECT_BIT 28
`define BOOT_ISA_BIT 3
`define BOOT_SINGLE_CACHE_BIT 1
`define BOOT_ISA_BLANK 1'b1

`endif

// ==== sysconf_pkg.sv ====
// Types shared by the system configuration bank
package sysconf_pkg;
    typedef logic [1:0] perm_group_t;
    typedef logic [31:0] word_t;
    typedef enum logic {
        ISA_COMPRESSED,
        ISA_STANDARD
    } isa_e;
    typedef enum {
        KEY_IDLE,
        KEY_HALF
    } key_state_e;
endpackage : sysconf_pkg

// ==== sysconf_unlock.sv ====
// Key sequence watcher that opens and closes the system lock
`timescale 1ns/1ps
`include "sysconf_params.svh"

module sysconf_unlock (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Key register writes
    input wire logic key_write_in,
    input wire sysconf_pkg::word_t key_data_in,
    // Any other bank write, breaks back-to-back pairing
    input wire logic other_write_in,
    // Lock state
    output logic unlocked_out
);
    import sysconf_pkg::*;

    key_state_e state;
    key_state_e next_state;
    logic unlocked;
    logic next_unlocked;

    always_comb begin
        next_state = state;
        next_unlocked = unlocked;
        unique case (state)
            KEY_IDLE: begin
                if (key_write_in) begin
                    next_unlocked = 1'b0;
                    if (key_data_in == `KEY_FIRST) begin
                        next_state = KEY_HALF;
                    end
                end
            end
            KEY_HALF: begin
                if (key_write_in) begin
                    next_unlocked = (key_data_in == `KEY_SECOND);
                    next_state = (key_data_in == `KEY_FIRST) ? KEY_HALF : KEY_IDLE;
                end else if (other_write_in) begin
                    next_state = KEY_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= KEY_IDLE;
            unlocked <= 1'b0;
        end else begin
            state <= next_state;
            unlocked <= next_unlocked;
        end
    end

    assign unlocked_out = unlocked;

    property p_key_pair_unlocks;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (key_write_in && key_data_in == `KEY_FIRST)
            ##1 (key_write_in && key_data_in == `KEY_SECOND) |=> unlocked;
    endproperty
    a_key_pair_unlocks: assert property (p_key_pair_unlocks)
        else $error("key pair did not unlock");

    property p_other_key_locks;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        (key_write_in && key_data_in != `KEY_SECOND) |=> !unlocked;
    endproperty
    a_other_key_locks: assert property (p_other_key_locks)
        else $error("non-key write left unlocked");

    property p_no_unlock_without_pair;
        @(posedge sys_clk_in) disable iff (!arst_n_in)
        $rose(unlocked) |-> $past(key_write_in) && $past(state == KEY_HALF);
    endproperty
    a_no_unlock_without_pair: assert property (p_no_unlock_without_pair)
        else $error("unlock without key pair");
endmodule : sysconf_unlock

// ==== sysconf_far_model.sv ====
// Far-side model: flash boot levels and JTAG user-id probe
`timescale 1ns/1ps
module sysconf_far_model (
    // Clock
    input wire logic sys_clk_in,
    // Requests from the bench
    input wire logic [5:0] boot_cfg_in,
    input wire logic probe_req_in,
    // Toward the bank
    output logic [5:0] flash_bits_out,
    output logic jtag_pulse_out
);
    // Flash levels only move while the bank sits in reset, so one stage is harmless
    always_ff @(posedge sys_clk_in) begin
        flash_bits_out <= boot_cfg_in;
        jtag_pulse_out <= probe_req_in;
    end
endmodule : sysconf_far_model

// ==== sysconf_bank_tb.sv ====
// Self-checking bench for the system configuration bank
`timescale 1ns/1ps
`include "sysconf_params.svh"
module sysconf_bank_tb;
    import sysconf_pkg::*;
    localparam logic [3:0] REV = 4'h5; // Arbitrary value
    localparam logic [27:0] DEV = 28'h0123456; // Arbitrary value
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [11:0] addr = 12'h000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_taken = 1'b0;
    word_t wdata = '0;
    word_t rdata;
    word_t v;
    word_t e;
    logic [5:0] cfg = 6'h35;
    logic [5:0] fl;
    logic probe = 1'b0;
    logic jp;
    logic dbg_path = 1'b0;
    logic dbg_isa = 1'b0;
    perm_group_t guest = 2'h0;
    perm_group_t cpu_grp;
    logic [15:0] jtag_id;
    wire [23:0] grp;
    logic isa_o, cache_o, cp_o, unl_o;
    word_t exp_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    logic [5:0] cases [4] = '{6'h15, 6'h25, 6'h3a, 6'h3d};

    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    sysconf_far_model far (.sys_clk_in(sys_clk_in), .boot_cfg_in(cfg), .probe_req_in(probe),
        .flash_bits_out(fl), .jtag_pulse_out(jp));

    sysconf_bank #(.REVISION_NUMBER(REV), .DEVICE_IDENTIFIER(DEV)) DUT (
        .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
        .reg_write_in(wr), .reg_read_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .flash_programmed_in(fl[5]), .flash_trusted_in(fl[4]), .flash_signed_in(fl[3]),
        .flash_code_protect_in(fl[2]), .flash_boot_isa_in(fl[1]),
        .flash_single_cache_in(fl[0]), .debug_boot_path_in(dbg_path),
        .debug_boot_instruction_set_in(dbg_isa), .core_guest_identifier_in(guest),
        .jtag_user_id_read_in(jp), .jtag_user_id_out(jtag_id),
        .usb_initiator_group_out(grp[23:22]), .quad_serial_initiator_group_out(grp[21:20]),
        .ethernet_initiator_group_out(grp[19:18]), .crypto_initiator_group_out(grp[17:16]),
        .second_can_initiator_group_out(grp[15:14]),
        .first_can_initiator_group_out(grp[13:12]),
        .converter_initiator_group_out(grp[11:10]), .wireless_initiator_group_out(grp[9:8]),
        .debug_initiator_group_out(grp[7:6]), .dma_initiator_group_out(grp[5:4]),
        .flash_controller_initiator_group_out(grp[3:2]),
        .cpu_code_initiator_group_out(grp[1:0]), .cpu_bus_group_out(cpu_grp),
        .boot_instruction_set_out(isa_o), .single_cache_route_select_out(cache_o),
        .code_protection_flag_out(cp_o), .system_unlocked_out(unl_o));

    task automatic check(input word_t seen, input word_t exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // Bus tasks leave the strobe up so back-to-back key writes stay adjacent
    task automatic wr_op(input logic [11:0] a, input word_t d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge sys_clk_in);
    endtask : wr_op

    task automatic rd_op(input logic [11:0] a, input word_t exp);
        exp_q.push_back(exp);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge sys_clk_in);
    endtask : rd_op

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge sys_clk_in);
    endtask : idle

    task automatic do_reset();
        arst_n_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        check(isa_o, 1'b1);
        arst_n_in <= 1'b1;
        idle(2);
    endtask : do_reset

    function automatic word_t boot_exp(input logic [5:0] c);
        logic good;
        good = c[5] & c[4];
        boot_exp = '0;
        boot_exp[31] = !good;
        boot_exp[29] = !c[3];
        boot_exp[28] = c[2];
        boot_exp[3] = good ? c[1] : 1'b1;
        boot_exp[1] = good & c[0];
    endfunction : boot_exp

    task automatic key_pair(input int gap, input logic split, input logic exp_unl);
        wr_op(`ADDR_SYSTEM_UNLOCK_KEY, `KEY_FIRST);
        // No zero-length idle: it would drive the strobe twice in one step
        if (gap > 0) begin
            idle(gap);
        end
        if (split) begin
            wr_op(`ADDR_USER_UNIQUE_ID, 32'h0);
        end
        wr_op(`ADDR_SYSTEM_UNLOCK_KEY, `KEY_SECOND);
        idle(2);
        @(negedge sys_clk_in);
        check(unl_o, exp_unl);
        @(posedge sys_clk_in);
    endtask : key_pair

    // Read data lands on the taking edge and is checked at the falling edge after it
    always @(posedge sys_clk_in) rd_taken <= rd;
    always @(negedge sys_clk_in) begin
        if (rd_taken) begin
            if (exp_q.size() == 0) begin
                check(rdata, 32'hdeadbeef);
            end else begin
                check(rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_errors++;
        test_done();
    end

    initial begin
        void'($urandom(80305));
        @(posedge sys_clk_in);
        do_reset();
        rd_op(`ADDR_PERMISSION_GROUPS, 32'h0);
        rd_op(`ADDR_USER_UNIQUE_ID, 32'h0);
        rd_op(`ADDR_SYSTEM_UNLOCK_KEY, 32'h0);
        rd_op(`ADDR_DEVICE_REVISION_ID, {REV, DEV});
        rd_op(12'h1f0, 32'h0);
        wr_op(`ADDR_PERMISSION_GROUPS, 32'hffffffff);
        wr_op(`ADDR_USER_UNIQUE_ID, 32'hffffffff);
        wr_op(`ADDR_BOOT_CONFIGURATION, 32'hffffffff);
        wr_op(`ADDR_DEVICE_REVISION_ID, 32'h0);
        rd_op(`ADDR_PERMISSION_GROUPS, 32'h0);
        rd_op(`ADDR_USER_UNIQUE_ID, 32'h0);
        rd_op(`ADDR_DEVICE_REVISION_ID, {REV, DEV});
        $display("locked access finished");
        key_pair(0, 1'b0, 1'b1);
        for (int i = 0; i < 6; i++) begin
            v = (i < 4) ? {16{i[1:0]}} : $urandom;
            guest <= v[31:30];
            wr_op(`ADDR_PERMISSION_GROUPS, v);
            wr_op(`ADDR_USER_UNIQUE_ID, v);
            rd_op(`ADDR_PERMISSION_GROUPS, {8'h00, v[23:0]});
            rd_op(`ADDR_USER_UNIQUE_ID, {16'h0000, v[15:0]});
            probe <= 1'b1;
            idle(1);
            probe <= 1'b0;
            idle(2);
            @(negedge sys_clk_in);
            check(grp, v[23:0]);
            check(jtag_id, v[15:0]);
            check(cpu_grp, v[31:30]);
            @(posedge sys_clk_in);
        end
        $display("group and user id finished");
        wr_op(`ADDR_SYSTEM_UNLOCK_KEY, 32'h33333333);
        wr_op(`ADDR_PERMISSION_GROUPS, 32'h0);
        rd_op(`ADDR_SYSTEM_UNLOCK_KEY, 32'h33333333);
        rd_op(`ADDR_PERMISSION_GROUPS, {8'h00, v[23:0]});
        idle(2);
        @(negedge sys_clk_in);
        check(unl_o, 1'b0);
        @(posedge sys_clk_in);
        key_pair(0, 1'b1, 1'b0);
        key_pair(3, 1'b0, 1'b1);
        wr_op(`ADDR_SYSTEM_UNLOCK_KEY, `KEY_FIRST);
        idle(2);
        @(negedge sys_clk_in);
        check(unl_o, 1'b0);
        @(posedge sys_clk_in);
        $display("key sequence finished");
        dbg_path <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            dbg_isa <= !j[0];
            idle(2);
            @(negedge sys_clk_in);
            check(isa_o, !j[0]);
            @(posedge sys_clk_in);
        end
        dbg_path <= 1'b0;
        $display("debug boot finished");
        // Each reset reloads the boot word, so every flash state gets its own reset
        for (int k = 0; k < 4; k++) begin
            cfg <= cases[k];
            idle(1);
            do_reset();
            e = boot_exp(cases[k]);
            rd_op(`ADDR_BOOT_CONFIGURATION, e);
            rd_op(`ADDR_PERMISSION_GROUPS, 32'h0);
            idle(1);
            @(negedge sys_clk_in);
            check(isa_o, e[3]);
            check(cache_o, e[1]);
            check(cp_o, e[28]);
            check(unl_o, 1'b0);
            @(posedge sys_clk_in);
        end
        $display("boot word finished");
        idle(3);
        if (exp_q.size() != 0) begin
            n_errors++;
        end
        test_done();
    end
endmodule : sysconf_bank_tb
